// ---- src/i2creg_top.sv ----
// serial-bus target giving register write and register read access
`timescale 1ns/10ps
`include "i2creg_cfg.svh"
module i2creg_top
    import i2creg_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic [1:0] ADDR_SELECT_LSB_PIN_IN,
    input wire logic [1:0] ADDR_SELECT_MID_PIN_IN,
    input wire logic [1:0] ADDR_SELECT_MSB_PIN_IN,
    output logic REG_WR_OUT,
    output logic [7:0] REG_WADDR_OUT,
    output logic [7:0] REG_WDATA_OUT,
    output logic [7:0] REG_RADDR_OUT,
    input wire logic [7:0] REG_RDATA_IN
);
    // start detection on the data line
    logic start_tgl_r;
    always_ff @(negedge SDA_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            start_tgl_r <= 1'b0;
        end else if (SCL_IN) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // link side, clocked by the bus clock
    logic sda_smp_r;
    logic [5:0] sel_meta_r;
    logic [5:0] sel_sync_r;
    always_ff @(posedge SCL_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sda_smp_r <= 1'b1;
            sel_meta_r <= 6'h00;
            sel_sync_r <= 6'h00;
        end else begin
            sda_smp_r <= SDA_IN;
            sel_meta_r <= {ADDR_SELECT_MSB_PIN_IN, ADDR_SELECT_MID_PIN_IN,
                           ADDR_SELECT_LSB_PIN_IN};
            sel_sync_r <= sel_meta_r;
        end
    end

    // tri-level code per pin: low 0, floating 1, high 2; lsb pin varies fastest
    function automatic logic [6:0] sel_val(input logic [1:0] code);
        sel_val = (code == `I2CREG_SEL_HIGH) ? 7'h02 :
                  (code == `I2CREG_SEL_FLOAT) ? 7'h01 : 7'h00;
    endfunction
    wire [6:0] own_addr = `I2CREG_ADDR_BASE + sel_val(sel_sync_r[1:0])
                        + 7'(`I2CREG_MID_WEIGHT * sel_val(sel_sync_r[3:2]))
                        + 7'(`I2CREG_MSB_WEIGHT * sel_val(sel_sync_r[5:4]));

    i2creg_state_e state_r;
    i2creg_state_e state_nxt;
    logic start_seen_r;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic ptr_tgl_r;
    logic wr_tgl_r;
    logic [7:0] rd_hold_r;

    wire start_pend = start_tgl_r != start_seen_r;
    wire [7:0] byte_in = {shift_r[6:0], sda_smp_r};
    wire last_bit = cnt_r == `I2CREG_LAST_BIT;
    wire addr_hit = byte_in[7:1] == own_addr;
    wire regnum_done = (state_r == I2CREG_REGNUM) && last_bit && !start_pend;
    wire wdata_done = (state_r == I2CREG_WDATA) && last_bit && !start_pend;

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        oe_nxt = 1'b0;
        ptr_nxt = ptr_r;
        wdata_nxt = wdata_r;
        if (start_pend) begin
            // a repeated start restarts decoding from any state
            state_nxt = I2CREG_ADDR;
            cnt_nxt = 3'h0;
        end else begin
            unique case (state_r)
                I2CREG_IDLE, I2CREG_IGNORE: begin
                    state_nxt = state_r;
                end
                I2CREG_ADDR: begin
                    shift_nxt = byte_in;
                    cnt_nxt = cnt_r + 3'h1;
                    if (last_bit) begin
                        state_nxt = addr_hit ? I2CREG_ACK_ADDR : I2CREG_IGNORE;
                        oe_nxt = addr_hit;
                    end
                end
                I2CREG_ACK_ADDR: begin
                    cnt_nxt = 3'h0;
                    if (shift_r[0] == `I2CREG_RW_READ) begin
                        state_nxt = I2CREG_RDATA;
                        shift_nxt = rd_hold_r;
                        oe_nxt = ~rd_hold_r[7];
                    end else begin
                        state_nxt = I2CREG_REGNUM;
                    end
                end
                I2CREG_REGNUM: begin
                    shift_nxt = byte_in;
                    cnt_nxt = cnt_r + 3'h1;
                    if (last_bit) begin
                        ptr_nxt = byte_in;
                        oe_nxt = 1'b1;
                        state_nxt = I2CREG_ACK_REGNUM;
                    end
                end
                I2CREG_ACK_REGNUM: begin
                    cnt_nxt = 3'h0;
                    state_nxt = I2CREG_WDATA;
                end
                I2CREG_WDATA: begin
                    shift_nxt = byte_in;
                    cnt_nxt = cnt_r + 3'h1;
                    if (last_bit) begin
                        wdata_nxt = byte_in;
                        oe_nxt = 1'b1;
                        state_nxt = I2CREG_ACK_WDATA;
                    end
                end
                I2CREG_ACK_WDATA: begin
                    state_nxt = I2CREG_IDLE;
                end
                I2CREG_RDATA: begin
                    shift_nxt = {shift_r[6:0], 1'b0};
                    cnt_nxt = cnt_r + 3'h1;
                    if (last_bit) begin
                        state_nxt = I2CREG_RACK;
                    end else begin
                        oe_nxt = ~shift_r[6];
                    end
                end
                I2CREG_RACK: begin
                    state_nxt = I2CREG_IDLE;
                end
            endcase
        end
    end

    // state moves on the falling edge so the line changes while the clock is low
    always_ff @(negedge SCL_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r <= I2CREG_IDLE;
            start_seen_r <= 1'b0;
            shift_r <= 8'h00;
            cnt_r <= 3'h0;
            oe_r <= 1'b0;
            ptr_r <= 8'h00;
            wdata_r <= 8'h00;
            ptr_tgl_r <= 1'b0;
            wr_tgl_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_seen_r <= start_tgl_r;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            oe_r <= oe_nxt;
            ptr_r <= ptr_nxt;
            wdata_r <= wdata_nxt;
            ptr_tgl_r <= ptr_tgl_r ^ regnum_done;
            wr_tgl_r <= wr_tgl_r ^ wdata_done;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = oe_r;

    // system side
    logic [2:0] ptr_sync_r;
    logic [2:0] wr_sync_r;
    logic load_r;
    i2creg_wreq_s wreq_r;
    logic wr_pulse_r;
    logic [7:0] raddr_r;
    wire ptr_evt = ptr_sync_r[2] ^ ptr_sync_r[1];
    wire wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

    // pointer and data words are stable long before their toggles arrive
    always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ptr_sync_r <= 3'h0;
            wr_sync_r <= 3'h0;
            load_r <= 1'b0;
            wreq_r <= '0;
            wr_pulse_r <= 1'b0;
            raddr_r <= 8'h00;
            rd_hold_r <= 8'h00;
        end else begin
            ptr_sync_r <= {ptr_sync_r[1:0], ptr_tgl_r};
            wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
            wr_pulse_r <= wr_evt;
            // reload one cycle after the pulse, once the user's store has landed
            load_r <= ptr_evt | wr_pulse_r;
            if (ptr_evt) begin
                raddr_r <= ptr_r;
            end
            if (wr_evt) begin
                wreq_r <= '{ptr: ptr_r, data: wdata_r};
            end
            if (load_r) begin
                rd_hold_r <= REG_RDATA_IN;
            end
        end
    end

    assign REG_WR_OUT = wr_pulse_r;
    assign REG_WADDR_OUT = wreq_r.ptr;
    assign REG_WDATA_OUT = wreq_r.data;
    assign REG_RADDR_OUT = raddr_r;
endmodule

// ---- src/i2creg_cfg.svh ----
// constants for the serial register access port
`ifndef I2CREG_CFG_SVH
`define I2CREG_CFG_SVH
`define I2CREG_ADDR_BASE 7'h08
`define I2CREG_SEL_LOW 2'h0
`define I2CREG_SEL_FLOAT 2'h1
`define I2CREG_SEL_HIGH 2'h2
`define I2CREG_MID_WEIGHT 7'h03
`define I2CREG_MSB_WEIGHT 7'h09
`define I2CREG_LAST_BIT 3'h7
`define I2CREG_RW_WRITE 1'h0
`define I2CREG_RW_READ 1'h1
`endif

// ---- src/i2creg_pkg.sv ----
// types for the serial register access port
package i2creg_pkg;
    typedef enum logic [3:0] {
        I2CREG_IDLE,
        I2CREG_ADDR,
        I2CREG_ACK_ADDR,
        I2CREG_REGNUM,
        I2CREG_ACK_REGNUM,
        I2CREG_WDATA,
        I2CREG_ACK_WDATA,
        I2CREG_RDATA,
        I2CREG_RACK,
        I2CREG_IGNORE
    } i2creg_state_e;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } i2creg_wreq_s;
endpackage

// ---- testbench/i2creg_props.sv ----
// assertions on the serial register port
`timescale 1ns/10ps
module i2creg_props(
    input wire logic SYS_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic REG_WR_OUT,
    input wire logic [7:0] REG_WADDR_OUT,
    input wire logic [7:0] REG_WDATA_OUT,
    input wire logic [7:0] REG_RADDR_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    sequence s_no_wr;
        !REG_WR_OUT [*8];
    endsequence
    chk_no_high: assert property (!SDA_OUT) else $error("sda driven");
    chk_oe_edge: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
        else $error("oe moved with scl high");
    chk_reset_idle: assert property ($rose(RESETN_IN) |-> !SDA_OE_OUT && !REG_WR_OUT)
        else $error("busy after reset");
    chk_wr_in_ack: assert property ($rose(REG_WR_OUT) |-> SDA_OE_OUT)
        else $error("store without ack");
    chk_wr_once: assert property (REG_WR_OUT |=> s_no_wr) else $error("double write");
    chk_wr_hold: assert property ($changed(REG_WDATA_OUT) || $changed(REG_WADDR_OUT)
        |-> REG_WR_OUT || $past(REG_WR_OUT)) else $error("write data moved");
    chk_ptr_in_ack: assert property ($changed(REG_RADDR_OUT) |-> ##[0:8] SDA_OE_OUT)
        else $error("pointer without ack");
    chk_wr_to_ptr: assert property (REG_WR_OUT |-> REG_WADDR_OUT == REG_RADDR_OUT)
        else $error("write off pointer");
endmodule
bind i2creg_top i2creg_props u_chk (.SYS_CLK_IN, .RESETN_IN, .SCL_IN, .SDA_OUT, .SDA_OE_OUT,
    .REG_WR_OUT, .REG_WADDR_OUT, .REG_WDATA_OUT, .REG_RADDR_OUT);

// ---- testbench/i2creg_bus_master.sv ----
// behavioural bus controller, 160 ns bit time
`timescale 1ns/10ps
module i2creg_bus_master(
    output logic scl_out = 1'h1,
    output logic pull_out = 1'h0,
    input wire logic sda_in
);
    // clock stays low first, so this also serves as repeated start
    task automatic start();
        #7 pull_out = 1'h0;
        #40 scl_out = 1'h1;
        #40 pull_out = 1'h1;
        #40 scl_out = 1'h0;
    endtask
    task automatic stop();
        #40 pull_out = 1'h1;
        #40 scl_out = 1'h1;
        #40 pull_out = 1'h0;
    endtask
    // msb first plus ack bit; a one only releases, the pull-up does the rest
    task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #40 pull_out = !tx[i];
            #40 scl_out = 1'h1;
            #40 rx[i] = sda_in;
            #40 scl_out = 1'h0;
        end
    endtask
endmodule

// ---- testbench/i2creg_bench.sv ----
// self-checking bench for the serial register port
`timescale 1ns/10ps
module i2creg_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h1;
    logic [1:0] s0 = 2'h0, s1 = 2'h0, s2 = 2'h0;
    logic scl, pull, oe, sdo, wr, mute = 1'h0, stray = 1'h0;
    logic [7:0] wa, wd, ra, regs [256];
    logic [8:0] rx;
    int err_count = 0, samples_checked = 0, wr_cnt = 0;
    wire logic sda = !(pull || oe);
    always #10 clk = ~clk;
    always @(posedge clk) wr_cnt <= wr_cnt + int'(wr);
    always @(posedge clk) if (wr) regs[wa] <= wd;
    always @(posedge scl) stray <= stray || (mute && oe);
    i2creg_top dut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sdo), .SDA_OE_OUT(oe), .ADDR_SELECT_LSB_PIN_IN(s0),
        .ADDR_SELECT_MID_PIN_IN(s1), .ADDR_SELECT_MSB_PIN_IN(s2), .REG_WR_OUT(wr),
        .REG_WADDR_OUT(wa), .REG_WDATA_OUT(wd), .REG_RADDR_OUT(ra), .REG_RDATA_IN(regs[ra]));
    i2creg_bus_master mst (.scl_out(scl), .pull_out(pull), .sda_in(sda));
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // start on a fixed offset from the system clock so edges never coincide
    task automatic go();
        @(posedge clk);
        mst.start();
    endtask
    task automatic put(input logic [7:0] b, input logic exp, input string what);
        mst.byte9({b, 1'h1}, rx);
        cmp(what, {7'h0, exp}, {7'h0, !rx[0]});
    endtask
    task automatic t_addr_table();
        logic [6:0] a;
        for (int i = 0; i < 27; i++) begin
            @(posedge clk);
            s0 <= 2'(i % 3);
            s1 <= 2'(i / 3 % 3);
            s2 <= 2'(i / 9);
            a = 7'(8 + i);
            go();
            put({a, 1'h0}, 1'h1, "own addr");
            mst.stop();
            go();
            mute = 1'h1;
            put({a + 7'h01, 1'h0}, 1'h0, "other addr");
            put(8'h00, 1'h0, "other byte");
            mute = 1'h0;
            mst.stop();
        end
        cmp("stray drive", 8'h0, {7'h0, stray});
        cmp("sda level", 8'h0, {7'h0, sdo});
    endtask
    task automatic t_write_read(input logic [7:0] r, input logic [7:0] d);
        int n;
        n = wr_cnt;
        go();
        put(8'h44, 1'h1, "wr addr");
        put(r, 1'h1, "reg num");
        put(d, 1'h1, "data");
        put(~d, 1'h0, "extra data");
        mst.stop();
        cmp("writes", 8'(n + 1), 8'(wr_cnt));
        cmp("write reg", r, wa);
        cmp("write data", d, wd);
        go();
        put(8'h44, 1'h1, "rd setup");
        put(r, 1'h1, "rd reg");
        go();
        put(8'h45, 1'h1, "rd addr");
        mst.byte9(9'h1fe, rx);
        mst.stop();
        cmp("read data", d, rx[8:1]);
        cmp("read reg", r, ra);
    endtask
    initial begin
        // a real falling edge, so the bus-clock side resets as well
        rst_n <= 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        t_addr_table();
        t_write_read(8'h3c, 8'ha5);
        t_write_read(8'hc3, 8'h5a);
        results();
    end
    // tests need about 0.2 ms
    initial begin
        #1000000;
        err_count++;
        results();
    end
endmodule
